// >>> hw/alu_status_flags.sv
// ALU status register, flag update control and addressing front end
//
// The implementer's own choices: the address map and strobed register access.
`timescale 1ns/1ps
// Function
// - Flag-affecting op aimed at status drops result, applies flags only
// - Clearing status sets zero flag, leaves other flags unchanged
// - Status bits seven to five are unimplemented and read zero
// - Negative flag copies result most significant bit
// - Overflow flag set when signed result sign wrongly changes
// - Zero flag set when result is zero, else cleared
// - Half carry flag takes carry out of bit three on add/sub
// - Carry flag takes carry out of top bit on add/sub
// - Subtract adds complement of second operand; carries mean no borrow
// - Rotate through carry loads carry with bit shifted out
// - Status register may be any instruction's operand
// - Data memory via inherent/literal/direct/indirect modes
// - Indexed literal offset mode only with extended set enabled
module alu_status_flags
   import alu_status_pkg::*;
#(
   parameter int W = 8,
   parameter int AW = 12,
   parameter logic [7:0] ACCESS_SPLIT = 8'h60
) (
   input logic clock,
   input logic sys_rst,
   input logic [2:0] reg_addr,
   input logic [7:0] reg_wdata,
   input logic reg_wr,
   input logic reg_rd,
   output logic [7:0] reg_rdata,
   input logic op_start,
   input alu_op_e op_code,
   input logic [W-1:0] op_w,
   input logic [W-1:0] op_f,
   input logic [$clog2(W)-1:0] op_bit,
   input logic op_src_status,
   input logic op_dst_status,
   output logic op_done,
   output logic [W-1:0] op_result,
   output logic op_result_wr,
   output logic [7:0] status_flags,
   input logic am_start,
   input addr_mode_e am_mode,
   input logic [7:0] am_literal,
   input logic am_access,
   output logic am_done,
   output logic [AW-1:0] am_ea,
   output logic am_uses_mem,
   output logic am_refused
);

   logic [4:0] status_q;
   logic ext_en_q;
   logic [AW-9:0] bank_q;
   logic [7:0] ptr_lo_q;
   logic [AW-9:0] ptr_hi_q;
   logic refused_q;
   logic [2:0] last_mode_q;
   logic [7:0] rdata_q;
   logic op_done_q;
   logic [W-1:0] op_result_q;
   logic op_result_wr_q;
   logic am_done_q;
   logic [AW-1:0] am_ea_q;
   logic am_uses_mem_q;
   logic am_refused_q;

   logic [W-1:0] status_byte;
   logic [W-1:0] f_operand;
   logic [W-1:0] calc_res;
   logic [FLAGS_W-1:0] calc_flags;
   logic [4:0] op_mask;
   logic flag_op;
   logic [4:0] status_d;
   logic [AW-1:0] pointer;
   logic [AW-1:0] ea_c;
   logic uses_mem_c;
   logic refused_c;
   logic wr_status;
   logic wr_astat;

   // Upper status bits are never stored, so they always read zero
   assign status_byte = {{(W-5){1'b0}}, status_q};

   // Status can feed the ALU like any other file operand
   assign f_operand = op_src_status ? status_byte : op_f;

   assign op_mask = flag_mask(op_code);
   assign flag_op = |op_mask;
   assign pointer = {ptr_hi_q, ptr_lo_q};
   assign wr_status = reg_wr && (reg_addr == REG_STATUS);
   assign wr_astat = reg_wr && (reg_addr == REG_ASTAT);

   alu_flag_calc #(
      .W(W)
   ) u_calc (
      .op(op_code),
      .w_val(op_w),
      .f_val(f_operand),
      .bit_sel(op_bit),
      .carry_in(status_q[FLAG_C]),
      .res(calc_res),
      .flags(calc_flags)
   );

   alu_addr_resolve #(
      .AW(AW),
      .ACCESS_SPLIT(ACCESS_SPLIT)
   ) u_addr (
      .mode(am_mode),
      .ext_enable(ext_en_q),
      .literal(am_literal),
      .access_bank(am_access),
      .bank(bank_q),
      .pointer(pointer),
      .ea(ea_c),
      .uses_mem(uses_mem_c),
      .refused(refused_c)
   );

   // Next status value; ALU activity outranks a software write
   always_comb begin
      status_d = status_q;
      if (op_start && flag_op) begin
         // Only permitted flags change, the rest hold their value
         status_d = (status_q & ~op_mask) | (calc_flags & op_mask);
      end else if (op_start && op_dst_status) begin
         // Flagless ops targeting status store their result there
         status_d = calc_res[4:0];
      end else if (wr_status) begin
         status_d = reg_wdata[4:0];
      end
   end

   // Status register; clear-file on it sets zero and keeps the other flags
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         status_q <= STATUS_RST;
      end else begin
         status_q <= status_d;
      end
   end

   // Result path; a flag op aimed at status never writes its result
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         op_done_q <= 1'b0;
         op_result_q <= '0;
         op_result_wr_q <= 1'b0;
      end else begin
         op_done_q <= op_start;
         op_result_wr_q <= op_start && !op_dst_status;
         if (op_start) begin
            op_result_q <= calc_res;
         end
      end
   end

   // Control: extended set enable steers the address decoder
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         ext_en_q <= CTRL_EXT_RST;
      end else if (reg_wr && (reg_addr == REG_CTRL)) begin
         ext_en_q <= reg_wdata[CTRL_EXT_BIT];
      end
   end

   // Bank select and pointer pair used by direct and indirect modes
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         bank_q <= NIBBLE_RST;
         ptr_lo_q <= BYTE_RST;
         ptr_hi_q <= NIBBLE_RST;
      end else if (reg_wr) begin
         if (reg_addr == REG_BANK) begin
            bank_q <= reg_wdata[AW-9:0];
         end
         if (reg_addr == REG_PTR_LO) begin
            ptr_lo_q <= reg_wdata;
         end
         if (reg_addr == REG_PTR_HI) begin
            ptr_hi_q <= reg_wdata[AW-9:0];
         end
      end
   end

   // Address resolution outputs, registered one cycle after the request
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         am_done_q <= 1'b0;
         am_ea_q <= '0;
         am_uses_mem_q <= 1'b0;
         am_refused_q <= 1'b0;
      end else begin
         am_done_q <= am_start;
         if (am_start) begin
            am_ea_q <= ea_c;
            am_uses_mem_q <= uses_mem_c;
            am_refused_q <= refused_c;
         end
      end
   end

   // Sticky refusal flag; a new refusal beats a write-one clear
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         refused_q <= 1'b0;
         last_mode_q <= 3'h0;
      end else begin
         if (am_start && refused_c) begin
            refused_q <= 1'b1;
         end else if (wr_astat && reg_wdata[ASTAT_REFUSED_BIT]) begin
            refused_q <= 1'b0;
         end
         if (am_start) begin
            last_mode_q <= am_mode;
         end
      end
   end

   // Read data one cycle after the strobe; unmapped offsets read zero
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         rdata_q <= BYTE_RST;
      end else if (reg_rd) begin
         unique case (reg_addr)
            REG_STATUS: rdata_q <= status_byte;
            REG_CTRL: rdata_q <= {7'h00, ext_en_q};
            REG_RESULT: rdata_q <= op_result_q;
            REG_BANK: rdata_q <= {4'h0, bank_q};
            REG_PTR_LO: rdata_q <= ptr_lo_q;
            REG_PTR_HI: rdata_q <= {4'h0, ptr_hi_q};
            REG_ASTAT: rdata_q <= {1'b0, last_mode_q, 3'h0, refused_q};
            default: rdata_q <= BYTE_RST;
         endcase
      end else begin
         rdata_q <= BYTE_RST;
      end
   end

   // Every output comes straight from a flip-flop
   assign reg_rdata = rdata_q;
   assign op_done = op_done_q;
   assign op_result = op_result_q;
   assign op_result_wr = op_result_wr_q;
   assign status_flags = {3'h0, status_q};
   assign am_done = am_done_q;
   assign am_ea = am_ea_q;
   assign am_uses_mem = am_uses_mem_q;
   assign am_refused = am_refused_q;

endmodule

// >>> shared/alu_status_pkg.sv
// Shared constants, types and decoders for the ALU status flag block
package alu_status_pkg;

   // Register port offsets (8-bit data, 3-bit address)
   localparam logic [2:0] REG_STATUS = 3'h0;
   localparam logic [2:0] REG_CTRL = 3'h1;
   localparam logic [2:0] REG_RESULT = 3'h2;
   localparam logic [2:0] REG_BANK = 3'h3;
   localparam logic [2:0] REG_PTR_LO = 3'h4;
   localparam logic [2:0] REG_PTR_HI = 3'h5;
   localparam logic [2:0] REG_ASTAT = 3'h6;

   // Status flag positions
   localparam int FLAG_C = 0;
   localparam int FLAG_DC = 1;
   localparam int FLAG_Z = 2;
   localparam int FLAG_OV = 3;
   localparam int FLAG_N = 4;
   localparam int FLAGS_W = 5;

   // Control and addressing status fields
   localparam int CTRL_EXT_BIT = 0;
   localparam int ASTAT_REFUSED_BIT = 0;
   localparam int ASTAT_MODE_LSB = 4;

   // Reset values
   localparam logic [4:0] STATUS_RST = 5'h00;
   localparam logic CTRL_EXT_RST = 1'b0;
   localparam logic [7:0] BYTE_RST = 8'h00;
   localparam logic [3:0] NIBBLE_RST = 4'h0;

   // Flag update masks
   localparam logic [4:0] MASK_NONE = 5'h00;
   localparam logic [4:0] MASK_ALL = 5'h1F;
   localparam logic [4:0] MASK_ZN = 5'h14;
   localparam logic [4:0] MASK_Z = 5'h04;
   localparam logic [4:0] MASK_CZN = 5'h15;

   typedef enum logic [4:0] {
      OP_ADD, OP_ADDC, OP_SUB, OP_SUBB, OP_INC, OP_DEC, OP_NEG,
      OP_AND, OP_IOR, OP_XOR, OP_COM, OP_RRC, OP_RLC, OP_CLR,
      OP_MOVF, OP_MOVFF, OP_MOVW, OP_SWAP, OP_BCF, OP_BSF
   } alu_op_e;

   typedef enum logic [2:0] {
      AM_INHERENT, AM_LITERAL, AM_DIRECT, AM_INDIRECT, AM_INDEXED
   } addr_mode_e;

   // Which status flags an operation is allowed to change
   function automatic logic [4:0] flag_mask(input alu_op_e op);
      logic [4:0] m;
      m = MASK_NONE;
      unique case (op)
         OP_ADD, OP_ADDC, OP_SUB, OP_SUBB,
         OP_INC, OP_DEC, OP_NEG: m = MASK_ALL;
         OP_AND, OP_IOR, OP_XOR, OP_COM, OP_MOVF: m = MASK_ZN;
         OP_RRC, OP_RLC: m = MASK_CZN;
         OP_CLR: m = MASK_Z;
         OP_MOVFF, OP_MOVW, OP_SWAP, OP_BCF, OP_BSF: m = MASK_NONE;
      endcase
      return m;
   endfunction

endpackage

// >>> hw/alu_flag_calc.sv
// Combinational ALU result and raw flag computation
`timescale 1ns/1ps
module alu_flag_calc
   import alu_status_pkg::*;
#(
   parameter int W = 8
) (
   input alu_op_e op,
   input logic [W-1:0] w_val,
   input logic [W-1:0] f_val,
   input logic [$clog2(W)-1:0] bit_sel,
   input logic carry_in,
   output logic [W-1:0] res,
   output logic [FLAGS_W-1:0] flags
);

   logic [W-1:0] x;
   logic [W-1:0] y;
   logic cin;
   logic add_path;
   logic c_out;
   logic [W:0] sum;
   logic [4:0] half;
   logic [W-1:0] bit_onehot;

   // One shared adder; subtract adds the complement plus one, subtract with borrow adds it plus carry
   always_comb begin
      x = f_val;
      y = w_val;
      cin = 1'b0;
      add_path = 1'b0;
      c_out = carry_in;
      res = '0;
      bit_onehot = W'(1) << bit_sel;
      unique case (op)
         OP_ADD: add_path = 1'b1;
         OP_ADDC: begin
            add_path = 1'b1;
            cin = carry_in;
         end
         OP_SUB: begin
            y = ~w_val;
            cin = 1'b1;
            add_path = 1'b1;
         end
         OP_SUBB: begin
            y = ~w_val;
            cin = carry_in;
            add_path = 1'b1;
         end
         OP_INC: begin
            y = '0;
            cin = 1'b1;
            add_path = 1'b1;
         end
         OP_DEC: begin
            y = '1;
            add_path = 1'b1;
         end
         OP_NEG: begin
            x = '0;
            y = ~f_val;
            cin = 1'b1;
            add_path = 1'b1;
         end
         OP_AND: res = f_val & w_val;
         OP_IOR: res = f_val | w_val;
         OP_XOR: res = f_val ^ w_val;
         OP_COM: res = ~f_val;
         OP_RRC: begin
            res = {carry_in, f_val[W-1:1]};
            c_out = f_val[0];
         end
         OP_RLC: begin
            res = {f_val[W-2:0], carry_in};
            c_out = f_val[W-1];
         end
         OP_CLR: res = '0;
         OP_MOVF: res = f_val;
         OP_MOVFF: res = f_val;
         OP_MOVW: res = w_val;
         OP_SWAP: res = {f_val[W/2-1:0], f_val[W-1:W/2]};
         OP_BCF: res = f_val & ~bit_onehot;
         OP_BSF: res = f_val | bit_onehot;
      endcase
      sum = {1'b0, x} + {1'b0, y} + {{W{1'b0}}, cin};
      half = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, cin};
      if (add_path) begin
         res = sum[W-1:0];
         c_out = sum[W];
      end
   end

   // Raw flags; the caller masks those the operation may change
   always_comb begin
      flags = '0;
      flags[FLAG_N] = res[W-1];
      flags[FLAG_OV] = add_path & (x[W-1] == y[W-1])
         & (sum[W-1] != x[W-1]);
      flags[FLAG_Z] = (res == '0);
      flags[FLAG_DC] = add_path & half[4];
      flags[FLAG_C] = c_out;
   end

endmodule

// >>> hw/alu_addr_resolve.sv
// Combinational data memory effective address resolution
`timescale 1ns/1ps
module alu_addr_resolve
   import alu_status_pkg::*;
#(
   parameter int AW = 12,
   parameter logic [7:0] ACCESS_SPLIT = 8'h60
) (
   input addr_mode_e mode,
   input logic ext_enable,
   input logic [7:0] literal,
   input logic access_bank,
   input logic [AW-9:0] bank,
   input logic [AW-1:0] pointer,
   output logic [AW-1:0] ea,
   output logic uses_mem,
   output logic refused
);

   // Inherent and literal modes touch no data memory location
   always_comb begin
      ea = '0;
      uses_mem = 1'b0;
      refused = 1'b0;
      unique case (mode)
         AM_INHERENT: uses_mem = 1'b0;
         AM_LITERAL: uses_mem = 1'b0;
         AM_DIRECT: begin
            uses_mem = 1'b1;
            if (!access_bank) begin
               ea = {bank, literal};
            end else if (literal < ACCESS_SPLIT) begin
               ea = {{(AW-8){1'b0}}, literal};
            end else begin
               ea = {{(AW-8){1'b1}}, literal};
            end
         end
         AM_INDIRECT: begin
            uses_mem = 1'b1;
            ea = pointer;
         end
         AM_INDEXED: begin
            // Only decoded while the extended set is on
            if (ext_enable) begin
               uses_mem = 1'b1;
               ea = pointer + {{(AW-8){1'b0}}, literal};
            end else begin
               refused = 1'b1;
            end
         end
         default: refused = 1'b1;
      endcase
   end

endmodule

// >>> verif/alu_status_flags_checker.sv
// Port-level assertions for the ALU status flag block
`timescale 1ns/1ps
module alu_status_flags_checker
   import alu_status_pkg::*;
#(
   parameter int W = 8
) (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic [2:0] reg_addr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic op_start,
   input wire alu_op_e op_code,
   input wire logic [W-1:0] op_w,
   input wire logic [W-1:0] op_f,
   input wire logic op_src_status,
   input wire logic op_dst_status,
   input wire logic op_done,
   input wire logic [W-1:0] op_result,
   input wire logic op_result_wr,
   input wire logic [7:0] status_flags,
   input wire logic am_start,
   input wire logic am_done
);
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   // Plain add with no carry in, so flags follow from the operands alone
   wire logic plain_add;
   wire logic [3:0] f_low;
   wire logic w_top;
   wire logic f_top;
   assign plain_add = op_start && op_code == OP_ADD && !op_src_status;
   assign f_low = op_f[3:0];
   assign w_top = op_w[W-1];
   assign f_top = op_f[W-1];

   upper_zero_a: assert property (status_flags[7:5] == 3'h0)
      else $error("status top bits not zero");
   done_pulse_a: assert property (op_start |=> op_done)
      else $error("op_done missing");
   result_wr_a: assert property (op_start |=>
      op_result_wr == !$past(op_dst_status))
      else $error("result write strobe wrong");
   neg_flag_a: assert property (plain_add |=>
      status_flags[4] == op_result[W-1]) else $error("negative flag wrong");
   zero_flag_a: assert property (plain_add |=>
      status_flags[2] == (op_result == '0)) else $error("zero flag wrong");
   carry_flag_a: assert property (plain_add |=>
      status_flags[0] == (op_result < $past(op_f)))
      else $error("carry flag wrong");
   half_flag_a: assert property (plain_add |=>
      status_flags[1] == (op_result[3:0] < $past(f_low)))
      else $error("half carry flag wrong");
   wrap_flag_a: assert property (plain_add |=>
      status_flags[3] == ($past(w_top) == $past(f_top)
      && op_result[W-1] != $past(w_top))) else $error("overflow flag wrong");
   clear_stat_a: assert property (op_start && op_code == OP_CLR
      && op_dst_status |=> status_flags == ($past(status_flags) | 8'h04))
      else $error("clear of status wrong");
   stat_read_a: assert property (reg_rd && reg_addr == REG_STATUS
      |=> reg_rdata == $past(status_flags)) else $error("status read wrong");
   am_done_a: assert property (am_start |=> am_done)
      else $error("am_done missing");
endmodule

bind alu_status_flags alu_status_flags_checker #(.W(W)) u_chk (
   .clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .op_start(op_start), .op_code(op_code),
   .op_w(op_w), .op_f(op_f), .op_src_status(op_src_status),
   .op_dst_status(op_dst_status), .op_done(op_done), .op_result(op_result),
   .op_result_wr(op_result_wr), .status_flags(status_flags),
   .am_start(am_start), .am_done(am_done));

// >>> verif/alu_status_flags_tb.sv
// Self-checking bench for the ALU status flag block
`timescale 1ns/1ps
module alu_status_flags_tb
   import alu_status_pkg::*;
;
   logic clock, sys_rst, reg_wr, reg_rd, op_start, op_src_status;
   logic op_dst_status, am_start, am_access;
   logic [2:0] reg_addr, op_bit;
   logic [7:0] reg_wdata, reg_rdata, op_w, op_f, op_result, am_literal;
   logic [7:0] status_flags;
   logic op_done, op_result_wr, am_done, am_uses_mem, am_refused;
   logic [11:0] am_ea;
   alu_op_e op_code;
   addr_mode_e am_mode;
   logic [4:0] st; // Expected flags
   int fail_count, checked;

   alu_status_flags u_alu_status_flags (.clock(clock), .sys_rst(sys_rst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .op_start(op_start),
      .op_code(op_code), .op_w(op_w), .op_f(op_f), .op_bit(op_bit),
      .op_src_status(op_src_status), .op_dst_status(op_dst_status),
      .op_done(op_done), .op_result(op_result), .op_result_wr(op_result_wr),
      .status_flags(status_flags), .am_start(am_start), .am_mode(am_mode),
      .am_literal(am_literal), .am_access(am_access), .am_done(am_done),
      .am_ea(am_ea), .am_uses_mem(am_uses_mem), .am_refused(am_refused));

   // Free-running 8 ns clock
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end

   task automatic chk(input logic [11:0] got, exp, input string what);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR %0t %s got %h want %h", $time, what, got, exp);
      end
   endtask

   task automatic close_out();
      $display("Counts: %0d mismatches, %0d checks", fail_count, checked);
      if (fail_count == 0 && checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // Reference adder: returns {N, OV, Z, DC, C, sum}
   function automatic logic [12:0] addf(input logic [7:0] a, b,
                                        input logic ci);
      logic [8:0] s;
      logic [4:0] h;
      s = {1'b0, a} + {1'b0, b} + 9'(ci);
      h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + 5'(ci);
      return {s[7], a[7] == b[7] && s[7] != a[7], s[7:0] == 8'h00, h[4],
              s[8], s[7:0]};
   endfunction

   task automatic rd(input logic [2:0] a, input logic [7:0] exp);
      @(posedge clock);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1 chk(12'(reg_rdata), 12'(exp), "read");
   endtask

   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clock);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask

   // One operation; result checked by caller, flags against st
   task automatic op(input alu_op_e c, input logic [7:0] w, f,
                     input logic dst);
      @(posedge clock);
      op_start <= 1'b1;
      op_code <= c;
      op_w <= w;
      op_f <= f;
      op_dst_status <= dst;
      @(posedge clock);
      op_start <= 1'b0;
      #1 chk(12'(op_done), 12'h001, "done");
      chk(12'(op_result_wr), 12'(!dst), "write strobe");
      chk(12'(status_flags), 12'({3'h0, st}), "flags");
   endtask

   task automatic am(input addr_mode_e m, input logic [7:0] lit,
                     input logic acc, input logic [11:0] ea,
                     input logic uses, refd);
      @(posedge clock);
      am_start <= 1'b1;
      am_mode <= m;
      am_literal <= lit;
      am_access <= acc;
      @(posedge clock);
      am_start <= 1'b0;
      #1 chk(12'(am_done), 12'h001, "am done");
      chk(am_ea, ea, "address");
      chk(12'({am_uses_mem, am_refused}), 12'({uses, refd}), "mode flags");
   endtask

   // Add and subtract families over sign, zero and borrow corners
   task automatic t_arith();
      logic [7:0] wv [4] = '{8'h01, 8'h01, 8'h80, 8'h0F};
      logic [7:0] fv [4] = '{8'h7F, 8'hFF, 8'h80, 8'h01};
      alu_op_e ops [4] = '{OP_ADD, OP_SUB, OP_ADDC, OP_SUBB};
      logic [12:0] e;
      logic [7:0] y;
      for (int i = 0; i < 4; i++) begin
         for (int k = 0; k < 4; k++) begin
            y = ops[k] inside {OP_SUB, OP_SUBB} ? ~wv[i] : wv[i];
            e = addf(fv[i], y, k < 2 ? ops[k] == OP_SUB : st[0]);
            st = e[12:8];
            op(ops[k], wv[i], fv[i], 1'b0);
            chk(12'(op_result), 12'(e[7:0]), "sum");
         end
      end
   endtask

   // Rotates through carry in both directions
   task automatic t_rotate();
      logic [7:0] r;
      wr(REG_STATUS, 8'h09);
      st = 5'h09;
      r = {st[0], 7'h01};
      st = {r[7], st[3], r == 8'h00, st[1], 1'b0};
      op(OP_RRC, 8'h00, 8'h02, 1'b0);
      chk(12'(op_result), 12'(r), "rotate right");
      r = {7'h00, st[0]};
      st = {r[7], st[3], r == 8'h00, st[1], 1'b1};
      op(OP_RLC, 8'h00, 8'h80, 1'b0);
      chk(12'(op_result), 12'(r), "rotate left");
   endtask

   // Status register as destination and as source
   task automatic t_status();
      wr(REG_STATUS, 8'hEA);
      rd(REG_STATUS, 8'h0A);
      st = 5'h0E;
      op(OP_CLR, 8'h00, 8'h33, 1'b1);
      st = 5'h1A;
      op(OP_ADD, 8'h01, 8'h7F, 1'b1);
      st = 5'h13;
      op(OP_MOVW, 8'h13, 8'h00, 1'b1);
      @(posedge clock);
      op_src_status <= 1'b1;
      st = 5'h00;
      op(OP_ADD, 8'h01, 8'hC0, 1'b0);
      @(posedge clock);
      op_src_status <= 1'b0;
      chk(12'(op_result), 12'h014, "status operand");
      rd(REG_RESULT, 8'h14);
   endtask

   // Remaining operations; the last two flagless ones rewrite status
   task automatic t_misc();
      alu_op_e ops [10] = '{OP_INC, OP_DEC, OP_NEG, OP_AND, OP_IOR,
         OP_XOR, OP_COM, OP_MOVF, OP_MOVFF, OP_SWAP};
      logic [7:0] wv [10] = '{8'h00, 8'h00, 8'h00, 8'h0F, 8'h80, 8'h5A,
         8'h00, 8'h00, 8'h00, 8'h00};
      logic [7:0] fv [10] = '{8'hFF, 8'h80, 8'h01, 8'hF0, 8'h01, 8'h5A,
         8'h7F, 8'h00, 8'h1B, 8'h31};
      logic [7:0] rv [10] = '{8'h00, 8'h7F, 8'hFF, 8'h00, 8'h81, 8'h00,
         8'h80, 8'h00, 8'h1B, 8'h13};
      logic [4:0] sv [10] = '{5'h07, 5'h09, 5'h10, 5'h04, 5'h10, 5'h04,
         5'h10, 5'h04, 5'h1B, 5'h13};
      for (int i = 0; i < 10; i++) begin
         st = sv[i];
         op(ops[i], wv[i], fv[i], i >= 8);
         chk(12'(op_result), 12'(rv[i]), "result");
      end
      // Bit clear and set applied to status read back as the operand
      @(posedge clock);
      op_src_status <= 1'b1;
      op_bit <= 3'h4;
      st = 5'h03;
      op(OP_BCF, 8'h00, 8'h00, 1'b1);
      @(posedge clock);
      op_bit <= 3'h2;
      st = 5'h07;
      op(OP_BSF, 8'h00, 8'h00, 1'b1);
      chk(12'(op_result), 12'h007, "bit set");
      @(posedge clock);
      op_src_status <= 1'b0;
   endtask

   // Addressing modes, with the indexed mode gated by the enable bit
   task automatic t_addr();
      wr(REG_BANK, 8'h05);
      wr(REG_PTR_LO, 8'h34);
      wr(REG_PTR_HI, 8'h12);
      am(AM_INHERENT, 8'h00, 1'b0, 12'h000, 1'b0, 1'b0);
      am(AM_LITERAL, 8'h55, 1'b0, 12'h000, 1'b0, 1'b0);
      am(AM_DIRECT, 8'h40, 1'b0, 12'h540, 1'b1, 1'b0);
      am(AM_DIRECT, 8'h70, 1'b1, 12'hF70, 1'b1, 1'b0);
      am(AM_INDIRECT, 8'h00, 1'b0, 12'h234, 1'b1, 1'b0);
      am(AM_INDEXED, 8'h10, 1'b0, 12'h000, 1'b0, 1'b1);
      rd(REG_ASTAT, 8'h41);
      wr(REG_CTRL, 8'h01);
      am(AM_INDEXED, 8'hF0, 1'b0, 12'h324, 1'b1, 1'b0);
      rd(REG_ASTAT, 8'h41);
      wr(REG_ASTAT, 8'h01);
      rd(REG_ASTAT, 8'h40);
   endtask

   // Guard against a hung run
   initial begin
      #200000;
      fail_count++;
      close_out();
   end

   initial begin
      {reg_wr, reg_rd, op_start, op_src_status, op_dst_status} = 5'h00;
      {am_start, am_access, reg_addr, op_bit} = 8'h00;
      {reg_wdata, op_w, op_f, am_literal} = 32'h0000_0000;
      op_code = OP_ADD;
      am_mode = AM_INHERENT;
      st = 5'h00;
      fail_count = 0;
      checked = 0;
      sys_rst = 1'b1;
      repeat (16) @(posedge clock);
      sys_rst <= 1'b0;
      // Every register and the unmapped slot read zero after reset
      for (int a = 0; a < 8; a++) begin
         rd(3'(a), 8'h00);
      end
      t_arith();
      t_rotate();
      t_status();
      t_misc();
      t_addr();
      close_out();
   end
endmodule
